// *** verilog/bmpc_defines.vh ***
// How it works
// RL1: aux switch follows bias switch register bit
// RL2: software picks wired mode for parallel linear
// RL3: a handover level field sets buck-linear crossover
// RL4: a spacing in buck, c spacing in linear
// RL5: pulse counts split by a/c mode
// RL6: parallel c is never an independent output
// RL7: b modes: 1 buck, 2 linear, 3 both
// RL8: active state uses active target code
// RL9: sleep state switches to sleep target code
// RL10: peak code per energy state
// RL11: start spacing 300 ns times (2k+1)
// RL12: software relaxes spacing limit after startup
// RL13: nonzero cap ends pulse by 70ns(1+4k)
// RL14: software uses on-time cap sparingly
// RL15: software ignores counts while capping
// RL16: b handover level sets buck-linear crossover
// RL17: linear regulators deliver counted pulses
// RL18: b moves to linear near dropout
// RL19: linear b shares b target codes
// RL20: c target: own alone, a target parallel
// RL21: software enables standalone c, mode not wired
// RL22: a moves to linear c near dropout
`ifndef BMPC_DEFINES_VH
`define BMPC_DEFINES_VH

// register indices
`define BMPC_REG_BIAS_SWITCH_REGISTER     4'h0
`define BMPC_REG_A_CTRL      4'h1
`define BMPC_REG_A_SPACING   4'h2
`define BMPC_REG_B_CTRL      4'h3
`define BMPC_REG_B_LIMITS    4'h4
`define BMPC_REG_B_ACT_TGT   4'h5
`define BMPC_REG_B_SLP_TGT   4'h6
`define BMPC_REG_B_PEAK      4'h7
`define BMPC_REG_A_TGT       4'h8
`define BMPC_REG_C_TGT       4'h9
`define BMPC_REG_SYS_CTRL    4'ha
`define BMPC_REG_STATUS      4'hb
`define BMPC_REG_CNT_A_LO    4'hc
`define BMPC_REG_CNT_A_HI    4'hd
`define BMPC_REG_CNT_C_LO    4'he
`define BMPC_REG_CNT_C_HI    4'hf

// mode encodings
`define BMPC_A_MODE_WIRED    3'h3
`define BMPC_B_MODE_BUCK     2'h1
`define BMPC_B_MODE_LINEAR   2'h2
`define BMPC_B_MODE_BOTH     2'h3

// reset values
`define BMPC_RST_BYTE        8'h00
`define BMPC_RST_A_MODE      3'h1
`define BMPC_RST_B_MODE      2'h1

// timing
`define BMPC_CLK_PERIOD_NS   5
`define BMPC_SPACING_UNIT_NS 300
`define BMPC_CAP_UNIT_NS     70
`define BMPC_SPACING_CYC     ((`BMPC_SPACING_UNIT_NS + `BMPC_CLK_PERIOD_NS - 1) / `BMPC_CLK_PERIOD_NS)
`define BMPC_CAP_CYC         (`BMPC_CAP_UNIT_NS / `BMPC_CLK_PERIOD_NS)

`endif

// *** verilog/bmpc_core.v ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "bmpc_defines.vh"

module bmpc_core
(
   input  wire        ref_clk_in,
   input  wire        nrst_in,
   input  wire [3:0]  addr_in,
   input  wire [7:0]  wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [7:0]  rdata_out,
   input  wire        a_pulse_req_in,
   input  wire        b_pulse_req_in,
   input  wire        a_peak_in,
   input  wire        b_peak_in,
   input  wire [3:0]  a_dropout_in,
   input  wire [3:0]  b_dropout_in,
   output wire        aux_switch_on_out,
   output wire        a_switch_pulse_out,
   output wire        c_linear_pulse_out,
   output wire        b_switch_pulse_out,
   output wire        b_linear_pulse_out,
   output reg  [7:0]  b_target_code_out,
   output reg  [3:0]  b_peak_code_out,
   output reg  [7:0]  c_target_code_out,
   output reg         c_independent_out
);

   // ====================================================
   // decode helpers
   // ====================================================
   function [11:0] spacing_cycles;
      input [3:0] code;
      reg   [31:0] full;
      begin
         full           = `BMPC_SPACING_CYC * (2 * code + 1);
         spacing_cycles = full[11:0];
      end
   endfunction

   function [11:0] cap_cycles;
      input [3:0] code;
      reg   [31:0] full;
      begin
         full       = `BMPC_CAP_CYC * (1 + 4 * code);
         cap_cycles = full[11:0];
      end
   endfunction

   // ====================================================
   // registers
   // ====================================================
   reg         aux_switch_control_q;
   reg  [2:0]  buckboost_mode_sel_q;
   reg  [2:0]  a_linear_handover_level_q;
   reg  [3:0]  a_pulse_spacing_limit_q;
   reg  [3:0]  c_linear_pulse_spacing_q;
   reg  [1:0]  buck_b_mode_sel_q;
   reg  [3:0]  b_on_time_cap_q;
   reg  [3:0]  b_pulse_spacing_limit_q;
   reg  [3:0]  b_linear_handover_level_q;
   reg  [7:0]  b_active_target_q;
   reg  [7:0]  b_sleep_target_q;
   reg  [3:0]  b_peak_code_q;
   reg  [3:0]  b_sleep_peak_code_q;
   reg  [7:0]  a_output_target_q;
   reg  [7:0]  c_target_q;
   reg         c_standalone_enable_q;
   reg         sleep_power_state_q;
   reg  [15:0] a_charge_count_q;
   reg  [15:0] c_charge_count_q;

   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         aux_switch_control_q      <= 1'b0;
         buckboost_mode_sel_q      <= `BMPC_RST_A_MODE;
         a_linear_handover_level_q <= 3'h0;
         a_pulse_spacing_limit_q   <= 4'h0;
         c_linear_pulse_spacing_q  <= 4'h0;
         buck_b_mode_sel_q         <= `BMPC_RST_B_MODE;
         b_on_time_cap_q           <= 4'h0;
         b_pulse_spacing_limit_q   <= 4'h0;
         b_linear_handover_level_q <= 4'h0;
         b_active_target_q         <= `BMPC_RST_BYTE;
         b_sleep_target_q          <= `BMPC_RST_BYTE;
         b_peak_code_q             <= 4'h0;
         b_sleep_peak_code_q       <= 4'h0;
         a_output_target_q         <= `BMPC_RST_BYTE;
         c_target_q                <= `BMPC_RST_BYTE;
         c_standalone_enable_q     <= 1'b0;
         sleep_power_state_q       <= 1'b0;
      end
      else if (wr_in)
      begin
         case (addr_in)
            `BMPC_REG_BIAS_SWITCH_REGISTER:
               aux_switch_control_q <= wdata_in[0];
            `BMPC_REG_A_CTRL:
            begin
               buckboost_mode_sel_q      <= wdata_in[2:0];
               a_linear_handover_level_q <= wdata_in[6:4];
            end
            `BMPC_REG_A_SPACING:
            begin
               a_pulse_spacing_limit_q  <= wdata_in[3:0];
               c_linear_pulse_spacing_q <= wdata_in[7:4];
            end
            `BMPC_REG_B_CTRL:
            begin
               buck_b_mode_sel_q <= wdata_in[1:0];
               b_on_time_cap_q   <= wdata_in[7:4];
            end
            `BMPC_REG_B_LIMITS:
            begin
               b_pulse_spacing_limit_q   <= wdata_in[3:0];
               b_linear_handover_level_q <= wdata_in[7:4];
            end
            `BMPC_REG_B_ACT_TGT: b_active_target_q <= wdata_in;
            `BMPC_REG_B_SLP_TGT: b_sleep_target_q  <= wdata_in;
            `BMPC_REG_B_PEAK:
            begin
               b_peak_code_q       <= wdata_in[3:0];
               b_sleep_peak_code_q <= wdata_in[7:4];
            end
            `BMPC_REG_A_TGT: a_output_target_q <= wdata_in;
            `BMPC_REG_C_TGT: c_target_q        <= wdata_in;
            `BMPC_REG_SYS_CTRL:
            begin
               c_standalone_enable_q <= wdata_in[0];
               sleep_power_state_q   <= wdata_in[1];
            end
            default: ;
         endcase
      end
   end

   assign aux_switch_on_out = aux_switch_control_q; // see RL1

   // ====================================================
   // input synchronisers
   // ====================================================
   reg  [11:0] sync1_q;
   reg  [11:0] sync2_q;

   // multi-bit dropout codes are slow analog levels; a torn sample only
   // shifts the handover decision by one pulse
   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         sync1_q <= 12'h000;
         sync2_q <= 12'h000;
      end
      else
      begin
         sync1_q <= {b_dropout_in, a_dropout_in, b_peak_in, a_peak_in,
                     b_pulse_req_in, a_pulse_req_in};
         sync2_q <= sync1_q;
      end
   end

   wire [1:0] req_s  = sync2_q[1:0];
   wire [1:0] peak_s = sync2_q[3:2];
   wire [3:0] a_drop = sync2_q[7:4];
   wire [3:0] b_drop = sync2_q[11:8];

   // ====================================================
   // mode selection
   // ====================================================
   wire a_parallel = (buckboost_mode_sel_q == `BMPC_A_MODE_WIRED);
   // dropout below the handover level means the linear path takes over
   wire a_want_lin = a_parallel && ({1'b0, a_linear_handover_level_q} > a_drop); // see RL3, RL22
   wire b_buck_ok  = (buck_b_mode_sel_q == `BMPC_B_MODE_BUCK) ||
                     (buck_b_mode_sel_q == `BMPC_B_MODE_BOTH);
   wire b_want_lin = (buck_b_mode_sel_q == `BMPC_B_MODE_LINEAR) ||
                     ((buck_b_mode_sel_q == `BMPC_B_MODE_BOTH) &&
                      (b_linear_handover_level_q > b_drop)); // see RL7, RL16, RL18
   wire b_enabled  = b_buck_ok || b_want_lin; // see RL7

   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         b_target_code_out <= `BMPC_RST_BYTE;
         b_peak_code_out   <= 4'h0;
         c_target_code_out <= `BMPC_RST_BYTE;
         c_independent_out <= 1'b0;
      end
      else
      begin
         // one code feeds both the buck and the linear b path
         b_target_code_out <= sleep_power_state_q ? b_sleep_target_q
                                                  : b_active_target_q; // see RL8, RL9, RL19
         b_peak_code_out   <= sleep_power_state_q ? b_sleep_peak_code_q
                                                  : b_peak_code_q; // see RL10
         c_target_code_out <= a_parallel ? a_output_target_q : c_target_q; // see RL20
         c_independent_out <= c_standalone_enable_q && !a_parallel; // see RL6
      end
   end

   // ====================================================
   // pulse engines: channel 0 is a/c, channel 1 is b
   // ====================================================
   localparam ST_IDLE = 2'b01;
   localparam ST_ON   = 2'b10;

   wire [1:0]  chan_en  = {b_enabled, 1'b1};
   wire [1:0]  want_lin = {b_want_lin, a_want_lin};
   wire [7:0]  cap_code = {b_on_time_cap_q, 4'h0};
   wire [1:0]  pulse_w;
   wire [1:0]  lin_w;
   wire [1:0]  start_w;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_chan
         reg  [1:0]  state_q;
         reg  [11:0] gap_q;
         reg  [11:0] on_q;
         reg         lin_q;
         wire [3:0]  sp_code;
         wire [3:0]  cap_k = cap_code[gi*4 +: 4];
         wire        start = (state_q == ST_IDLE) && chan_en[gi] && req_s[gi] &&
                             (gap_q == 12'h000);
         wire        cap_hit = (cap_k != 4'h0) &&
                               (on_q >= cap_cycles(cap_k) - 12'h001); // see RL13

         if (gi == 0)
         begin : g_a
            // buck uses its own spacing, linear c uses its own
            assign sp_code = a_want_lin ? c_linear_pulse_spacing_q
                                        : a_pulse_spacing_limit_q; // see RL4
         end
         else
         begin : g_b
            assign sp_code = b_pulse_spacing_limit_q;
         end

         always @(posedge ref_clk_in)
         begin
            if (!nrst_in)
            begin
               state_q <= ST_IDLE;
               gap_q   <= 12'h000;
               on_q    <= 12'h000;
               lin_q   <= 1'b0;
            end
            else
            begin
               // gap counts from pulse start, so spacing is start to start
               if (start)
                  gap_q <= spacing_cycles(sp_code) - 12'h001; // see RL11
               else if (gap_q != 12'h000)
                  gap_q <= gap_q - 12'h001;
               case (state_q)
                  ST_IDLE:
                  begin
                     on_q <= 12'h000;
                     if (start)
                     begin
                        state_q <= ST_ON;
                        // path frozen for the pulse so counts land in one bank
                        lin_q   <= want_lin[gi];
                     end
                  end
                  ST_ON:
                  begin
                     on_q <= on_q + 12'h001;
                     if (peak_s[gi] || cap_hit)
                        state_q <= ST_IDLE;
                  end
                  default: state_q <= ST_IDLE;
               endcase
            end
         end

         // linear paths deliver the same bounded pulses as the switcher
         assign pulse_w[gi] = (state_q == ST_ON); // see RL17
         assign lin_w[gi]   = lin_q;
         assign start_w[gi] = start;
      end
   endgenerate

   assign a_switch_pulse_out = pulse_w[0] & ~lin_w[0];
   assign c_linear_pulse_out = pulse_w[0] &  lin_w[0]; // see RL22
   assign b_switch_pulse_out = pulse_w[1] & ~lin_w[1];
   assign b_linear_pulse_out = pulse_w[1] &  lin_w[1]; // see RL18

   // ====================================================
   // charge counters
   // ====================================================
   // counts saturate rather than wrap so a stale read is never low
   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         a_charge_count_q <= 16'h0000;
         c_charge_count_q <= 16'h0000;
      end
      else if (start_w[0])
      begin
         if (a_want_lin)
         begin
            if (c_charge_count_q != 16'hffff)
               c_charge_count_q <= c_charge_count_q + 16'h0001; // see RL5
         end
         else if (a_charge_count_q != 16'hffff)
            a_charge_count_q <= a_charge_count_q + 16'h0001; // see RL5
      end
   end

   // ====================================================
   // read port
   // ====================================================
   wire [7:0] status_w = {2'b00, c_independent_out, a_parallel,
                          lin_w[1], lin_w[0], pulse_w[1], pulse_w[0]};
   reg  [7:0] rd_d;

   always @*
   begin
      case (addr_in)
         `BMPC_REG_BIAS_SWITCH_REGISTER:   rd_d = {7'h00, aux_switch_control_q};
         `BMPC_REG_A_CTRL:    rd_d = {1'b0, a_linear_handover_level_q, 1'b0,
                                      buckboost_mode_sel_q};
         `BMPC_REG_A_SPACING: rd_d = {c_linear_pulse_spacing_q, a_pulse_spacing_limit_q};
         `BMPC_REG_B_CTRL:    rd_d = {b_on_time_cap_q, 2'b00, buck_b_mode_sel_q};
         `BMPC_REG_B_LIMITS:  rd_d = {b_linear_handover_level_q, b_pulse_spacing_limit_q};
         `BMPC_REG_B_ACT_TGT: rd_d = b_active_target_q;
         `BMPC_REG_B_SLP_TGT: rd_d = b_sleep_target_q;
         `BMPC_REG_B_PEAK:    rd_d = {b_sleep_peak_code_q, b_peak_code_q};
         `BMPC_REG_A_TGT:     rd_d = a_output_target_q;
         `BMPC_REG_C_TGT:     rd_d = c_target_q;
         `BMPC_REG_SYS_CTRL:  rd_d = {6'h00, sleep_power_state_q, c_standalone_enable_q};
         `BMPC_REG_STATUS:    rd_d = status_w;
         `BMPC_REG_CNT_A_LO:  rd_d = a_charge_count_q[7:0];
         `BMPC_REG_CNT_A_HI:  rd_d = a_charge_count_q[15:8];
         `BMPC_REG_CNT_C_LO:  rd_d = c_charge_count_q[7:0];
         `BMPC_REG_CNT_C_HI:  rd_d = c_charge_count_q[15:8];
         default:             rd_d = 8'h00;
      endcase
   end

   // data stands only in the cycle after the strobe
   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
         rdata_out <= 8'h00;
      else if (rd_in)
         rdata_out <= rd_d;
      else
         rdata_out <= 8'h00;
   end

endmodule // bmpc_core

// *** test/bmpc_core_monitor.sv ***
`timescale 1ns/1ps
module bmpc_core_monitor
(
   input wire       ref_clk_in,
   input wire       nrst_in,
   input wire [3:0] addr_in,
   input wire [7:0] wdata_in,
   input wire       wr_in,
   input wire       rd_in,
   input wire [7:0] rdata_out,
   input wire       a_peak_in,
   input wire       b_pulse_req_in,
   input wire       b_peak_in,
   input wire       aux_switch_on_out,
   input wire       a_switch_pulse_out,
   input wire       c_linear_pulse_out,
   input wire       b_switch_pulse_out,
   input wire       b_linear_pulse_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   wire        b_on = b_switch_pulse_out | b_linear_pulse_out;
   wire        a_on = a_switch_pulse_out | c_linear_pulse_out;
   reg         b_on_q;
   reg  [11:0] b_since_q;
   // ==========
   // cycles since last b start, parked at max so reset never looks like a start
   always @(posedge ref_clk_in)
   begin
      b_on_q <= b_on;
      if (!nrst_in)
         b_since_q <= 12'hfff;
      else if (b_on && !b_on_q)
         b_since_q <= 12'h000;
      else if (b_since_q != 12'hfff)
         b_since_q <= b_since_q + 12'h001;
   end
   aux_follow_a: assert property (wr_in && addr_in == 4'h0 |=>
      aux_switch_on_out == $past(wdata_in[0])) else $error("aux switch missed its write");
   aux_read_a: assert property (rd_in && addr_in == 4'h0 |=>
      rdata_out[0] == aux_switch_on_out) else $error("aux bit read back wrong");
   rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data not zero outside read");
   b_space_a: assert property (b_on && !b_on_q |-> b_since_q >= 12'h03b)
      else $error("b pulse starts too close");
   b_path_a: assert property (!(b_switch_pulse_out && b_linear_pulse_out))
      else $error("b switch and linear pulse together");
   a_path_a: assert property (!(a_switch_pulse_out && c_linear_pulse_out))
      else $error("a switch and c linear pulse together");
   b_req_a: assert property ($rose(b_on) |-> $past(b_pulse_req_in, 3))
      else $error("b pulse without request");
   b_peak_end_a: assert property (b_peak_in [*6] |-> !b_on)
      else $error("b pulse outlived peak");
   a_peak_end_a: assert property (a_peak_in [*6] |-> !a_on)
      else $error("a pulse outlived peak");
endmodule // bmpc_core_monitor

bind bmpc_core bmpc_core_monitor mon_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .a_peak_in(a_peak_in), .b_pulse_req_in(b_pulse_req_in),
   .b_peak_in(b_peak_in), .aux_switch_on_out(aux_switch_on_out),
   .a_switch_pulse_out(a_switch_pulse_out), .c_linear_pulse_out(c_linear_pulse_out),
   .b_switch_pulse_out(b_switch_pulse_out), .b_linear_pulse_out(b_linear_pulse_out));

// *** test/bmpc_load_model.sv ***
`timescale 1ns/1ps
module bmpc_load_model
(
   input  wire ref_clk_in,
   input  wire nrst_in,
   input  wire hungry_in,
   input  wire slow_in,
   input  wire pulse_in,
   output reg  req_out,
   output reg  peak_out
);
   reg [3:0] on_q;
   reg [1:0] tail_q;
   // ==========
   // inductor peak reached after a few cycles; slow load never peaks
   always @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         req_out <= 1'b0;
         peak_out <= 1'b0;
         on_q <= 4'h0;
         tail_q <= 2'h0;
      end
      else
      begin
         req_out <= hungry_in;
         on_q <= pulse_in ? on_q + {3'h0, on_q != 4'hf} : 4'h0;
         tail_q <= pulse_in ? 2'h3 : tail_q - {1'b0, tail_q != 2'h0};
         // comparator lingers a little after the pulse, like a slow sense path
         peak_out <= !slow_in && ((pulse_in && on_q >= 4'h3) || (peak_out && tail_q != 2'h0));
      end
   end
endmodule // bmpc_load_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "bmpc_defines.vh"
`define BMPC_CHK(got, exp) \
   begin \
      n_checks = n_checks + 1; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch = n_mismatch + 1; \
         $display("CHECK FAILED at %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module tb_top;
   reg        ref_clk_in = 1'b0;
   reg        nrst_in = 1'b0;
   reg  [3:0] addr_in = 4'h0;
   reg  [7:0] wdata_in = 8'h00;
   reg        wr_in = 1'b0;
   reg        rd_in = 1'b0;
   reg  [3:0] a_drop = 4'h0;
   reg  [3:0] b_drop = 4'h0;
   reg        a_hungry = 1'b0;
   reg        b_hungry = 1'b0;
   reg        b_slow = 1'b0;
   reg        b_prev = 1'b0;
   reg  [1:0] a_path = 2'b00;
   reg  [7:0] rv;
   wire [7:0] rdata_out, b_tgt, c_tgt;
   wire [3:0] b_pk;
   wire       a_req, b_req, a_peak, b_peak, aux_on, a_sw, c_lin, b_sw, b_lin, c_indep;
   wire       b_on = b_sw | b_lin;
   integer    n_mismatch = 0;
   integer    n_checks = 0;
   integer    cyc = 0;
   integer    b_gap = 0;
   integer    b_len = 0;
   integer    gap_c = 0;
   integer    len_c = 0;
   integer    i;

   always #2.5 ref_clk_in = ~ref_clk_in;

   bmpc_core dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .a_pulse_req_in(a_req), .b_pulse_req_in(b_req), .a_peak_in(a_peak),
      .b_peak_in(b_peak), .a_dropout_in(a_drop), .b_dropout_in(b_drop),
      .aux_switch_on_out(aux_on), .a_switch_pulse_out(a_sw), .c_linear_pulse_out(c_lin),
      .b_switch_pulse_out(b_sw), .b_linear_pulse_out(b_lin), .b_target_code_out(b_tgt),
      .b_peak_code_out(b_pk), .c_target_code_out(c_tgt), .c_independent_out(c_indep));
   bmpc_load_model a_load_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .hungry_in(a_hungry), .slow_in(1'b0), .pulse_in(a_sw | c_lin),
      .req_out(a_req), .peak_out(a_peak));
   bmpc_load_model b_load_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .hungry_in(b_hungry), .slow_in(b_slow), .pulse_in(b_on),
      .req_out(b_req), .peak_out(b_peak));

   // ==========
   // b pulse spacing and width, plus the hang guard
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      gap_c <= gap_c + 1;
      if (b_on)
         len_c <= len_c + 1;
      if (b_on && !b_prev)
      begin
         b_gap <= gap_c;
         gap_c <= 1;
         len_c <= 1;
      end
      if (!b_on && b_prev)
         b_len <= len_c;
      b_prev <= b_on;
      // path of the latest a/c pulse, switch bit above linear bit
      if (a_sw | c_lin)
         a_path <= {a_sw, c_lin};
      if (cyc == 10000)
      begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end

   task tick(input integer n);
      begin
         repeat (n) @(posedge ref_clk_in);
         #1;
      end
   endtask

   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge ref_clk_in);
         addr_in <= a;
         wdata_in <= d;
         wr_in <= 1'b1;
         @(posedge ref_clk_in);
         wr_in <= 1'b0;
      end
   endtask

   task rd(input [3:0] a);
      begin
         @(posedge ref_clk_in);
         addr_in <= a;
         rd_in <= 1'b1;
         @(posedge ref_clk_in);
         rd_in <= 1'b0;
         #1 rv = rdata_out;
      end
   endtask

   task chk(input [3:0] a, input [7:0] e);
      begin
         rd(a);
         `BMPC_CHK(rv, e)
      end
   endtask

   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial
   begin
      tick(12);
      nrst_in <= 1'b1;
      for (i = 0; i < 16; i = i + 1)
         chk(i[3:0], (i == 1 || i == 3) ? 8'h01 : 8'h00);
      wr(4'hc, 8'h55);
      chk(4'hc, 8'h00);
      wr(4'h0, 8'h01);
      chk(4'h0, 8'h01);
      `BMPC_CHK(aux_on, 1'b1)
      wr(4'h5, 8'h12);
      wr(4'h6, 8'h34);
      wr(4'h7, 8'h5a);
      tick(2);
      `BMPC_CHK({b_tgt, b_pk}, 12'h12a)
      wr(4'ha, 8'h02);
      tick(2);
      `BMPC_CHK({b_tgt, b_pk}, 12'h345)
      wr(4'h8, 8'h66);
      wr(4'h9, 8'h77);
      wr(4'ha, 8'h01);
      tick(2);
      `BMPC_CHK({c_indep, c_tgt}, 9'h177)
      wr(4'h1, 8'h03);
      tick(2);
      `BMPC_CHK({c_indep, c_tgt}, 9'h066)
      wr(4'h4, 8'h80);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(4'h3, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h03);
         b_drop <= (i == 3) ? 4'hf : 4'h2;
         b_hungry <= 1'b1;
         // hungry to pulse takes four edges, so the pulse stands here
         tick(8);
         `BMPC_CHK({b_sw, b_lin}, (i == 1 || i == 2) ? 2'b01 : 2'b10)
         b_hungry <= 1'b0;
         tick(80);
      end
      wr(4'h3, 8'h01);
      wr(4'h4, 8'h81);
      b_hungry <= 1'b1;
      tick(500);
      `BMPC_CHK(b_gap >= 180 && b_gap <= 181, 1'b1)
      wr(4'h3, 8'h11);
      b_slow <= 1'b1;
      tick(400);
      `BMPC_CHK(b_len, 70)
      wr(4'h3, 8'h01);
      tick(400);
      `BMPC_CHK(b_on, 1'b1)
      b_slow <= 1'b0;
      b_hungry <= 1'b0;
      // c spacing 1 in linear, a spacing 0 in switching
      wr(4'h2, 8'h10);
      wr(4'h1, 8'h43);
      a_drop <= 4'h2;
      a_hungry <= 1'b1;
      tick(850);
      `BMPC_CHK(a_path, 2'b01)
      chk(4'he, 8'h05);
      chk(4'hc, 8'h00);
      a_drop <= 4'hf;
      tick(900);
      `BMPC_CHK(a_path, 2'b10)
      rd(4'hc);
      `BMPC_CHK(rv >= 8'h0e && rv <= 8'h10, 1'b1)
      give_verdict;
   end
endmodule // tb_top
